/* test/lsmie_exec_asserts.sv */
// Purpose: port checks for the execution block
// Assumes: one wait cycle per access
// Notes:   flags are tied to their causes on the bus
`timescale 1ns/10ps
`include "lsmie_params.svh"
module lsmie_exec_asserts (
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        zeroFlag,
	input wire logic        carryFlag
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// request seen in an idle cycle
	wire logic take;
	// or-immediate executed with a nonzero literal
	wire logic orNz;
	assign take = (read | write) & waitrequest;
	assign orNz = take & write & (byteenable == 4'hF) & (address == `LSMIE_OFF_CTRL)
		& (writedata[19:16] == 4'h1) & (writedata[7:0] != 8'h00);
	chk_answer_one: assert property (take |=> !waitrequest)
		else $error("no answer after one wait");
	chk_single_ack: assert property (!waitrequest |=> waitrequest)
		else $error("answer held too long");
	chk_idle_wait: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("answer without request");
	chk_flags_kept: assert property (!take |=> $stable({zeroFlag, carryFlag}))
		else $error("flags moved without an access");
	chk_partial_be: assert property (write && byteenable != 4'hF |=> $stable(zeroFlag))
		else $error("partial write changed zero");
	chk_or_nonzero: assert property (orNz |=> !zeroFlag && $stable(carryFlag))
		else $error("or with nonzero literal gave zero");
	chk_rd_stands: assert property (!read |=> $stable(readdata))
		else $error("read data moved");
	chk_status_read: assert property (take && read && address == `LSMIE_OFF_STATUS
		|=> readdata[1:0] == {carryFlag, zeroFlag})
		else $error("status read mismatch");
	chk_unmapped_rd: assert property (take && read && address == 8'h18 |=> readdata == 0)
		else $error("unmapped read not zero");
	cover property (orNz);
	cover property (take && read);
	cover property (write && byteenable != 4'hF);
endmodule

/* test/lsmie_exec_bench.sv */
// Purpose: directed bench for the execution block
// Assumes: memory written before it is read
// Notes:   file f sits at byte 0x80+f
`timescale 1ns/10ps
`include "lsmie_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %0t: got %h want %h", $time, g, e); end end
module lsmie_exec_bench;
	logic        ref_clk = 0;
	logic        reset_n = 0;
	logic [7:0]  address = 8'h00;
	logic        read = 0;
	logic        write = 0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic [31:0] rv;
	logic        waitrequest;
	logic        zeroFlag;
	logic        carryFlag;
	int          err_count = 0;
	int          compares = 0;
	int          cycles = 0;
	lsmie_exec dut (.ref_clk(ref_clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .zeroFlag(zeroFlag), .carryFlag(carryFlag));
	initial forever #4 ref_clk = ~ref_clk;
	// a hang counts as a mismatch
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			summarize();
		end
	end
	task summarize;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// held until waitrequest is low at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		address <= a;
		write <= w;
		read <= ~w;
		writedata <= d;
		// waitrequest and read data are both taken at the rising edge
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		rv = readdata;
		write <= 0;
		read <= 0;
	endtask
	task ex(input logic [3:0] op, input logic d, input logic [6:0] f, input logic [7:0] k);
		bus(1, `LSMIE_OFF_CTRL, {12'h000, op, d, f, k});
	endtask
	task t_or;
		bus(1, `LSMIE_OFF_WORK, 32'h0000_0050);
		ex(4'h1, 1'b0, 7'h00, 8'h0A);
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK(rv[7:0], 8'h5A)
		bus(1, `LSMIE_OFF_WORK, 0);
		ex(4'h1, 1'b0, 7'h00, 8'h00);
		`CHK(zeroFlag, 1'b1)
		// partial strobes must not execute
		byteenable <= 4'h3;
		ex(4'h1, 1'b0, 7'h00, 8'hFF);
		byteenable <= 4'hF;
		// an unknown code leaves the work register alone
		ex(4'h7, 1'b0, 7'h00, 8'hFF);
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK(rv[7:0], 8'h00)
		bus(0, 8'h18, 0);
		`CHK(rv, 32'h0000_0000)
		// an or keeps carry and leaves zero clear
		bus(1, `LSMIE_OFF_STATUS, 32'h0000_0002);
		ex(4'h1, 1'b0, 7'h00, 8'h01);
		bus(0, `LSMIE_OFF_STATUS, 0);
		`CHK(rv[1:0], 2'b10)
	endtask
	task t_orf;
		bus(1, 8'h90, 32'h0000_000F);
		bus(1, `LSMIE_OFF_WORK, 32'h0000_00F0);
		ex(4'h2, 1'b1, 7'h10, 8'h00);
		bus(0, 8'h90, 0);
		`CHK(rv[7:0], 8'hFF)
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK(rv[7:0], 8'hF0)
		ex(4'h2, 1'b0, 7'h10, 8'h00);
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK(rv[7:0], 8'hFF)
	endtask
	task t_shift;
		bus(1, 8'h85, 32'h0000_0081);
		ex(4'h3, 1'b0, 7'h05, 8'h00);
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK({rv[7:0], carryFlag, zeroFlag}, 10'h00A)
		ex(4'h4, 1'b1, 7'h05, 8'h00);
		bus(0, 8'h85, 0);
		`CHK({rv[7:0], carryFlag}, 9'h081)
		bus(1, 8'h85, 32'h0000_0001);
		ex(4'h4, 1'b0, 7'h05, 8'h00);
		`CHK({carryFlag, zeroFlag}, 2'b11)
		ex(4'h3, 1'b1, 7'h05, 8'h00);
		bus(0, 8'h85, 0);
		`CHK({rv[7:0], carryFlag, zeroFlag}, 10'h008)
	endtask
	task t_move;
		bus(1, 8'h87, 0);
		ex(4'h5, 1'b1, 7'h07, 8'h00);
		`CHK(zeroFlag, 1'b1)
		bus(1, 8'h87, 32'h0000_003C);
		ex(4'h5, 1'b0, 7'h07, 8'h00);
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK({rv[7:0], zeroFlag}, 9'h078)
	endtask
	task ind(input logic n, input logic [1:0] m, input logic rel, input logic [5:0] k,
		input logic [15:0] p, input logic [15:0] pe, input logic [15:0] ea, input logic [7:0] v);
		bus(1, n ? `LSMIE_OFF_PTR1 : `LSMIE_OFF_PTR0, {16'h0000, p});
		bus(1, `LSMIE_OFF_CTRL, {2'b00, k, rel, n, m, 4'h6, 16'h0000});
		`CHK(zeroFlag, v == 8'h00)
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK(rv[7:0], v)
		bus(0, n ? `LSMIE_OFF_PTR1 : `LSMIE_OFF_PTR0, 0);
		`CHK(rv[15:0], pe)
		bus(0, `LSMIE_OFF_ADDR, 0);
		`CHK(rv[15:0], ea)
	endtask
	task t_ind;
		bus(1, `LSMIE_OFF_PTR0, 0);
		bus(1, 8'h80, 0);
		bus(1, `LSMIE_OFF_PTR0, 32'h0000_0010);
		bus(1, 8'h80, 32'h0000_0033);
		ex(4'h5, 1'b0, 7'h00, 8'h00);
		bus(0, `LSMIE_OFF_WORK, 0);
		`CHK(rv[7:0], 8'h33)
		// a bus read of the port follows the pointer as well
		bus(1, `LSMIE_OFF_PTR0, 0);
		bus(0, 8'h80, 0);
		`CHK(rv[7:0], 8'h00)
		ind(0, 2'b00, 0, 6'h00, 16'h000F, 16'h0010, 16'h0010, 8'h33);
		ind(1, 2'b01, 0, 6'h00, 16'h0011, 16'h0010, 16'h0010, 8'h33);
		ind(0, 2'b10, 0, 6'h00, 16'h0010, 16'h0011, 16'h0010, 8'h33);
		ind(1, 2'b11, 0, 6'h00, 16'h0000, 16'hFFFF, 16'h0000, 8'h00);
		ind(0, 2'b00, 0, 6'h00, 16'hFFFF, 16'h0000, 16'h0000, 8'h00);
		ind(1, 2'b00, 1, 6'h20, 16'h0030, 16'h0030, 16'h0010, 8'h33);
		ind(0, 2'b00, 1, 6'h1F, 16'hFFF1, 16'hFFF1, 16'h0010, 8'h33);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1;
		t_or;
		t_orf;
		t_shift;
		t_move;
		t_ind;
		summarize;
	end
endmodule
bind lsmie_exec lsmie_exec_asserts chk (.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
	.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
	.readdata(readdata), .waitrequest(waitrequest), .zeroFlag(zeroFlag), .carryFlag(carryFlag));

/* verilog/lsmie_exec.sv */
// Purpose: executes or-immediate, or-file, shifts, file move, indirect load
// Assumes: Avalon-MM slave with waitrequest, 32-bit data, ref_clk 125 MHz
// Notes:   a full-word write of CTRL executes one instruction; 128-byte file, 256-byte memory
//          data memory is indexed by the low byte of an effective address only
//          memories have no reset, so software fills them before reading them
// Function
// - or literal into work register, zero flag
// - or addressed file register, zero flag
// - destination bit picks work or file
// - left shift: bit7 to carry, zero in
// - right shift: bit0 to carry, zero in
// - move file to destination, zero flag
// - indirect load via pointer 0 or 1
// - mode field selects pre/post inc/dec
// - relative offset -32..31, pointer unchanged
// - indirect data port redirects to pointer
// - pointers wrap modulo 16 bits
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "lsmie_params.svh"

module lsmie_exec (
	// clock and asynchronous reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// Avalon-MM slave, one wait cycle per access
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// status flags, also readable at the status offset
	output logic             zeroFlag,
	output logic             carryFlag
);
	// file registers, data memory, work register, pointers
	logic [7:0]  fileMem [0:127];
	// indirect target space; only the low byte of a pointer or effective address picks a byte
	logic [7:0]  dataMem [0:255];
	// working register and both full-width pointers
	logic [7:0]  work_r,    work_nxt;
	logic [15:0] ptr_r [0:1];
	logic [15:0] ptr_nxt [0:1];
	// flags kept apart so each instruction touches only its own
	logic        zero_r,    zero_nxt;
	logic        carry_r,   carry_nxt;
	// effective address of the most recent indirect load
	logic [15:0] lastAddr_r, lastAddr_nxt;
	// bus answer: read data, acknowledge and registered wait
	logic [31:0] rdata_r,   rdata_nxt;
	logic        ack_r,     ack_nxt;
	logic        wait_r,    wait_nxt;
	// file write-back request of the current instruction
	logic        fileWe;
	logic [6:0]  fileWa;
	logic [7:0]  fileWd;

	// decoded control word
	// fields are meaningful only while the control offset is written
	logic [7:0]  litVal;
	logic [6:0]  fileAdr;
	logic        dstBit;
	logic [3:0]  opCode;
	logic [1:0]  modeVal;
	logic        ptrSel;
	logic        relMode;
	logic [5:0]  ofsVal;
	// one-cycle strobes of the access being taken
	logic        execNow;
	logic        regAcc;

	// slices of writedata; positions come from the shared header
	assign litVal  = writedata[`LSMIE_CTRL_LIT_LSB +: 8];
	assign fileAdr = writedata[`LSMIE_CTRL_ADR_LSB +: 7];
	assign dstBit  = writedata[`LSMIE_CTRL_DST_BIT];
	assign opCode  = writedata[`LSMIE_CTRL_OP_LSB +: 4];
	assign modeVal = writedata[`LSMIE_CTRL_MM_LSB +: 2];
	assign ptrSel  = writedata[`LSMIE_CTRL_N_BIT];
	assign relMode = writedata[`LSMIE_CTRL_REL_BIT];
	assign ofsVal  = writedata[`LSMIE_CTRL_OFS_LSB +: 6];
	// a request completes on the cycle after it is first seen
	assign regAcc  = (read | write) & ~ack_r;
	// partial strobes never execute, so a stray byte write is harmless
	assign execNow = write & ~ack_r & (address == `LSMIE_OFF_CTRL) & (&byteenable);

	// read of a file location; indirect data ports never hold storage
	// the pointer is used as it stands, before any step of this access
	function automatic logic [7:0] fileRead(input logic [6:0] a,
		input logic [15:0] p0, input logic [15:0] p1);
		if (a == `LSMIE_INDF0_ADDR)
			return dataMem[p0[7:0]];
		else if (a == `LSMIE_INDF1_ADDR)
			return dataMem[p1[7:0]];
		// every other address is a plain file register
		else
			return fileMem[a];
	endfunction

	// instruction execution and bus answer
	// one pass decides the next value of every register
	always_comb begin
		logic [7:0]  opnd;
		logic [7:0]  res;
		logic [15:0] base;
		logic [15:0] adj;
		logic [15:0] ea;
		logic        updZ;
		// temporaries start at zero so no latch is inferred
		opnd = 8'h00;
		res  = 8'h00;
		base = 16'h0000;
		adj  = 16'h0000;
		ea   = 16'h0000;
		updZ = 1'b0;
		// every state holds unless an access below changes it
		work_nxt     = work_r;
		ptr_nxt[0]   = ptr_r[0];
		ptr_nxt[1]   = ptr_r[1];
		zero_nxt     = zero_r;
		carry_nxt    = carry_r;
		lastAddr_nxt = lastAddr_r;
		rdata_nxt    = rdata_r;
		ack_nxt      = regAcc;
		// waitrequest is the inverse of the acknowledge, in its own flop
		wait_nxt     = ~regAcc;
		fileWe       = 1'b0;
		fileWa       = fileAdr;
		fileWd       = 8'h00;
		if (execNow) begin
			// operand fetched for every code; codes without it drop it
			opnd = fileRead(fileAdr, ptr_r[0], ptr_r[1]);
			case (lsmie_pkg::lsmie_op_e'(opCode))
				lsmie_pkg::LSMIE_OR_IMMEDIATE_OP: begin
					res      = work_r | litVal;
					work_nxt = res;
					updZ     = 1'b1;
				end
				lsmie_pkg::LSMIE_OR_FILE_OP: begin
					res  = work_r | opnd;
					updZ = 1'b1;
				end
				lsmie_pkg::LSMIE_SHIFT_LEFT_OP: begin
					res       = {opnd[6:0], 1'b0};
					carry_nxt = opnd[7];
					updZ      = 1'b1;
				end
				lsmie_pkg::LSMIE_SHIFT_RIGHT_OP: begin
					res       = {1'b0, opnd[7:1]};
					carry_nxt = opnd[0];
					updZ      = 1'b1;
				end
				lsmie_pkg::LSMIE_MOVE_FILE_OP: begin
					res  = opnd;
					updZ = 1'b1;
				end
				lsmie_pkg::LSMIE_INDIRECT_LOAD: begin
					base = ptr_r[ptrSel];
					if (relMode) begin
						ea = base + {{10{ofsVal[5]}}, ofsVal};
					end else begin
						adj = modeVal[0] ? base - 16'h0001 : base + 16'h0001;
						ea  = modeVal[1] ? base : adj;
						// flags ignore the pointer step
						ptr_nxt[ptrSel] = adj;
					end
					// only the low byte of the address reaches data memory
					res          = dataMem[ea[7:0]];
					work_nxt     = res;
					lastAddr_nxt = ea;
					updZ         = 1'b1;
				end
				// unknown codes do nothing
				default: begin
					updZ = 1'b0;
				end
			endcase
			if (opCode == lsmie_pkg::LSMIE_OR_FILE_OP ||
				opCode == lsmie_pkg::LSMIE_SHIFT_LEFT_OP ||
				opCode == lsmie_pkg::LSMIE_SHIFT_RIGHT_OP ||
				opCode == lsmie_pkg::LSMIE_MOVE_FILE_OP) begin
				// destination bit one writes back, zero goes to work
				if (dstBit) begin
					fileWe = 1'b1;
					fileWd = res;
				end else begin
					work_nxt = res;
				end
			end
			if (updZ)
				zero_nxt = (res == 8'h00);
		end else if (write & ~ack_r & (&byteenable)) begin
			// direct software writes to state
			// a control write never lands here, so no double action
			case (address)
				// working register and pointers take the low bits
				`LSMIE_OFF_WORK: work_nxt   = writedata[7:0];
				`LSMIE_OFF_PTR0: ptr_nxt[0] = writedata[15:0];
				`LSMIE_OFF_PTR1: ptr_nxt[1] = writedata[15:0];
				`LSMIE_OFF_STATUS: begin
					zero_nxt  = writedata[`LSMIE_ST_Z_BIT];
					carry_nxt = writedata[`LSMIE_ST_C_BIT];
				end
				default: begin
					// upper half of the map is the file; ports reach memory
					if (address[7]) begin
						fileWe = 1'b1;
						fileWa = address[6:0];
						fileWd = writedata[7:0];
					end
				end
			endcase
		end
		// read data; unmapped offsets answer zero
		// loaded at the taking edge so it stands through the answer cycle
		if (read & ~ack_r) begin
			case (address)
				// registers read back as stored, upper bits zero
				`LSMIE_OFF_STATUS: rdata_nxt = {30'h0000_0000, carry_r, zero_r};
				`LSMIE_OFF_WORK:   rdata_nxt = {24'h00_0000, work_r};
				`LSMIE_OFF_PTR0:   rdata_nxt = {16'h0000, ptr_r[0]};
				`LSMIE_OFF_PTR1:   rdata_nxt = {16'h0000, ptr_r[1]};
				`LSMIE_OFF_ADDR:   rdata_nxt = {16'h0000, lastAddr_r};
				default: begin
					// file reads share the redirect of the instruction path
					if (address[7])
						rdata_nxt = {24'h00_0000, fileRead(address[6:0], ptr_r[0], ptr_r[1])};
					else
						rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	// asynchronous reset sets every bus and flag flop to idle
	// state registers; wait drops one cycle after a request appears
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			work_r     <= `LSMIE_RST_BYTE;
			ptr_r[0]   <= `LSMIE_RST_PTR;
			ptr_r[1]   <= `LSMIE_RST_PTR;
			zero_r     <= 1'b0;
			carry_r    <= 1'b0;
			lastAddr_r <= `LSMIE_RST_PTR;
			rdata_r    <= 32'h0000_0000;
			ack_r      <= 1'b0;
			// waitrequest rests high so no answer is seen early
			wait_r     <= 1'b1;
		end else begin
			// every state moves on each edge; holds come from the next values
			work_r     <= work_nxt;
			ptr_r[0]   <= ptr_nxt[0];
			ptr_r[1]   <= ptr_nxt[1];
			zero_r     <= zero_nxt;
			carry_r    <= carry_nxt;
			lastAddr_r <= lastAddr_nxt;
			rdata_r    <= rdata_nxt;
			ack_r      <= ack_nxt;
			wait_r     <= wait_nxt;
		end
	end

	// file storage; memory contents are not reset
	// no reset keeps the arrays plain memories rather than flop banks
	always_ff @(posedge ref_clk) begin
		if (fileWe && fileWa != `LSMIE_INDF0_ADDR && fileWa != `LSMIE_INDF1_ADDR)
			fileMem[fileWa] <= fileWd;
	end

	// data memory is filled through the two port addresses
	// the write uses the pointer before any step of the same access
	always_ff @(posedge ref_clk) begin
		if (fileWe && fileWa == `LSMIE_INDF0_ADDR)
			dataMem[ptr_r[0][7:0]] <= fileWd;
		else if (fileWe && fileWa == `LSMIE_INDF1_ADDR)
			dataMem[ptr_r[1][7:0]] <= fileWd;
	end

	// outputs straight from flip-flops
	// wires only, so every output is a register's own value
	always_comb begin
		readdata    = rdata_r;
		waitrequest = wait_r;
		zeroFlag    = zero_r;
		carryFlag   = carry_r;
	end
endmodule

/* verilog/lsmie_params.svh */
// Purpose: constants for the logic/shift/move/indirect execution block
// Assumes: 32-bit Avalon-MM register word, byte addresses
// Notes:   offsets are byte addresses of aligned words
`ifndef LSMIE_PARAMS_SVH
`define LSMIE_PARAMS_SVH

// register byte offsets
`define LSMIE_OFF_CTRL     8'h00
`define LSMIE_OFF_STATUS   8'h04
`define LSMIE_OFF_WORK     8'h08
`define LSMIE_OFF_PTR0     8'h0C
`define LSMIE_OFF_PTR1     8'h10
`define LSMIE_OFF_ADDR     8'h14
`define LSMIE_OFF_FILE     8'h80
// indirect data port file addresses
`define LSMIE_INDF0_ADDR   7'h00
`define LSMIE_INDF1_ADDR   7'h01
// control field positions
`define LSMIE_CTRL_LIT_LSB 0
`define LSMIE_CTRL_ADR_LSB 8
`define LSMIE_CTRL_DST_BIT 15
`define LSMIE_CTRL_OP_LSB  16
`define LSMIE_CTRL_MM_LSB  20
`define LSMIE_CTRL_N_BIT   22
`define LSMIE_CTRL_REL_BIT 23
`define LSMIE_CTRL_OFS_LSB 24
// status bit positions
`define LSMIE_ST_Z_BIT     0
`define LSMIE_ST_C_BIT     1
// reset values
`define LSMIE_RST_BYTE     8'h00
`define LSMIE_RST_PTR      16'h0000
// timing: fixed slave latency of one wait cycle
`define LSMIE_WAIT_CYCLES  1

`endif

/* verilog/lsmie_pkg.sv */
// Purpose: shared types of the execution block
// Assumes: nothing
// Notes:   operation codes sit in control bits 19:16
package lsmie_pkg;
	// operation selector
	typedef enum logic [3:0] {
		LSMIE_OR_IMMEDIATE_OP = 4'h1,
		LSMIE_OR_FILE_OP      = 4'h2,
		LSMIE_SHIFT_LEFT_OP   = 4'h3,
		LSMIE_SHIFT_RIGHT_OP  = 4'h4,
		LSMIE_MOVE_FILE_OP    = 4'h5,
		LSMIE_INDIRECT_LOAD   = 4'h6
	} lsmie_op_e;
	// pointer mode field encoding
	typedef enum logic [1:0] {
		LSMIE_PRE_INC  = 2'b00,
		LSMIE_PRE_DEC  = 2'b01,
		LSMIE_POST_INC = 2'b10,
		LSMIE_POST_DEC = 2'b11
	} lsmie_mode_e;
endpackage
